// ---- design/bfm_pkg.sv ----
// Shared constants and types for the bidirectional queue, mailbox and parity block.
package bfm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Geometry.
  localparam int unsigned DATA_W   = 36;
  localparam int unsigned DEPTH    = 64;
  localparam int unsigned PTR_W    = 6;
  localparam int unsigned CNT_W    = 7;
  localparam int unsigned BYTE_W   = 9;
  localparam int unsigned NUM_BYTE = 4;
  localparam int unsigned NUM_Q    = 2;
  localparam int unsigned Q_A_TO_B = 0;
  localparam int unsigned Q_B_TO_A = 1;
  localparam logic [CNT_W-1:0] CNT_FULL = 7'h40;
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Offset presets chosen by the strap captured during reset.
  localparam logic [CNT_W-1:0] X_PRESET0 = 7'h08;
  localparam logic [CNT_W-1:0] X_PRESET1 = 7'h10;
  localparam logic [CNT_W-1:0] X_PRESET2 = 7'h18;
  localparam logic [CNT_W-1:0] X_PRESET3 = 7'h04;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses.
  localparam int unsigned AXI_AW = 4;
  localparam logic [AXI_AW-1:0] OFS_CTRL   = 4'h0;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] OFS_LEVEL  = 4'h8;
  localparam int unsigned CTRL_ODD_BIT = 0;
  localparam logic CTRL_ODD_RST = 1'b1;
  localparam int unsigned LEVEL_B_LSB = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Flag group of one queue, all active high meaning space or data present.
  typedef struct packed {
    logic not_empty;
    logic almost_empty_n;
    logic almost_full_n;
    logic not_full;
  } bfm_flags_type;

  localparam bfm_flags_type FLAGS_RST = '{1'b0, 1'b0, 1'b1, 1'b1};

  // Decoded port operations.
  typedef struct packed {
    logic fifo_wr;
    logic fifo_rd;
    logic mail_wr;
    logic mail_rd;
  } bfm_op_type;

endpackage

// ---- design/bfm_top.sv ----
// Bidirectional 64 x 36 queue pair with mailboxes, parity and a register slave.
`timescale 1ns/1ps

module bfm_top (
  // Clock and reset.
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Offset strap, sampled while reset is held.
  input  wire logic [1:0]                  offset_select,
  // Port A control.
  input  wire logic                        porta_chip_select_n,
  input  wire logic                        porta_write_not_read,
  input  wire logic                        porta_enable,
  input  wire logic                        porta_mailbox_select,
  input  wire logic                        porta_parity_generate,
  // Port A data bus.
  input  wire logic [bfm_pkg::DATA_W-1:0]  porta_data_in,
  output logic      [bfm_pkg::DATA_W-1:0]  porta_data_out,
  output logic                             porta_data_oe,
  // Port A flags.
  output logic                             porta_not_empty,
  output logic                             porta_almost_empty_n,
  output logic                             porta_almost_full_n,
  output logic                             porta_not_full,
  output logic                             porta_parity_error_n,
  output logic                             b_to_a_mail_flag_n,
  // Port B control.
  input  wire logic                        portb_chip_select_n,
  input  wire logic                        portb_write_not_read,
  input  wire logic                        portb_enable,
  input  wire logic                        portb_mailbox_select,
  input  wire logic                        portb_parity_generate,
  // Port B data bus.
  input  wire logic [bfm_pkg::DATA_W-1:0]  portb_data_in,
  output logic      [bfm_pkg::DATA_W-1:0]  portb_data_out,
  output logic                             portb_data_oe,
  // Port B flags.
  output logic                             portb_not_empty,
  output logic                             portb_almost_empty_n,
  output logic                             portb_almost_full_n,
  output logic                             portb_not_full,
  output logic                             portb_parity_error_n,
  output logic                             a_to_b_mail_flag_n,
  // AXI4-Lite write channels.
  input  wire logic [bfm_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [bfm_pkg::AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////////
  // Parity helpers.

  // Returns high when any byte fails the selected parity.
  function automatic logic parity_fail(input logic [bfm_pkg::DATA_W-1:0] d, input logic odd);
    logic fail;
    fail = 1'b0;
    for (int i = 0; i < bfm_pkg::NUM_BYTE; i++) begin
      // Odd select fails on an odd count of low bits, even select on an even count.
      fail = fail | (odd ? ~^d[i*bfm_pkg::BYTE_W +: bfm_pkg::BYTE_W]
                         : ^d[i*bfm_pkg::BYTE_W +: bfm_pkg::BYTE_W]);
    end
    return fail;
  endfunction

  // Replaces the top bit of each byte with parity of its lower eight bits.
  function automatic logic [bfm_pkg::DATA_W-1:0] parity_fill(
      input logic [bfm_pkg::DATA_W-1:0] d, input logic odd);
    logic [bfm_pkg::DATA_W-1:0] r;
    r = d;
    for (int i = 0; i < bfm_pkg::NUM_BYTE; i++) begin
      r[i*bfm_pkg::BYTE_W + bfm_pkg::BYTE_W - 1] =
        odd ? ~^d[i*bfm_pkg::BYTE_W +: bfm_pkg::BYTE_W-1]
            : ^d[i*bfm_pkg::BYTE_W +: bfm_pkg::BYTE_W-1];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Port decode.

  logic                       odd_q;
  logic [bfm_pkg::CNT_W-1:0]  x_q;
  bfm_pkg::bfm_op_type        op_a;
  bfm_pkg::bfm_op_type        op_b;
  wire logic                  sel_a = ~porta_chip_select_n & porta_enable;
  wire logic                  sel_b = ~portb_chip_select_n & portb_enable;

  assign op_a.fifo_wr = sel_a & porta_write_not_read & ~porta_mailbox_select;
  assign op_a.mail_wr = sel_a & porta_write_not_read & porta_mailbox_select;
  assign op_a.fifo_rd = sel_a & ~porta_write_not_read & ~porta_mailbox_select;
  assign op_a.mail_rd = sel_a & ~porta_write_not_read & porta_mailbox_select;
  assign op_b.fifo_wr = sel_b & portb_write_not_read & ~portb_mailbox_select;
  assign op_b.mail_wr = sel_b & portb_write_not_read & portb_mailbox_select;
  assign op_b.fifo_rd = sel_b & ~portb_write_not_read & ~portb_mailbox_select;
  assign op_b.mail_rd = sel_b & ~portb_write_not_read & portb_mailbox_select;

  ////////////////////////////////////////////////////////////////////////////////
  // Offset register, loaded from the strap while reset is held.

  wire logic [bfm_pkg::CNT_W-1:0] x_preset =
    (offset_select == 2'h0) ? bfm_pkg::X_PRESET0 :
    (offset_select == 2'h1) ? bfm_pkg::X_PRESET1 :
    (offset_select == 2'h2) ? bfm_pkg::X_PRESET2 : bfm_pkg::X_PRESET3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_q <= x_preset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Queues: index 0 is written by port A, index 1 by port B.

  logic [bfm_pkg::NUM_Q-1:0]        q_wr_req;
  logic [bfm_pkg::NUM_Q-1:0]        q_rd_req;
  logic [bfm_pkg::NUM_Q-1:0]        q_pg;
  logic [bfm_pkg::DATA_W-1:0]       q_wdata [bfm_pkg::NUM_Q];
  logic [bfm_pkg::DATA_W-1:0]       q_out_q [bfm_pkg::NUM_Q];
  logic [bfm_pkg::CNT_W-1:0]        cnt_q   [bfm_pkg::NUM_Q];
  bfm_pkg::bfm_flags_type           flag_q  [bfm_pkg::NUM_Q];

  assign q_wr_req = {op_b.fifo_wr, op_a.fifo_wr};
  assign q_rd_req = {op_a.fifo_rd, op_b.fifo_rd};
  assign q_pg     = {porta_parity_generate, portb_parity_generate};
  assign q_wdata[bfm_pkg::Q_A_TO_B] = porta_data_in;
  assign q_wdata[bfm_pkg::Q_B_TO_A] = portb_data_in;

  for (genvar q = 0; q < bfm_pkg::NUM_Q; q++) begin : g_queue
    logic [bfm_pkg::DATA_W-1:0] mem [bfm_pkg::DEPTH];
    logic [bfm_pkg::PTR_W-1:0]  wr_ptr_q;
    logic [bfm_pkg::PTR_W-1:0]  rd_ptr_q;
    logic [bfm_pkg::CNT_W-1:0]  cnt_d;
    bfm_pkg::bfm_flags_type     raw_d;
    bfm_pkg::bfm_flags_type     stage_q;
    bfm_pkg::bfm_flags_type     stage2_q;
    wire logic wr_ok = q_wr_req[q] & flag_q[q].not_full;
    wire logic rd_ok = q_rd_req[q] & flag_q[q].not_empty;

    assign cnt_d = cnt_q[q] + {{(bfm_pkg::CNT_W-1){1'b0}}, wr_ok}
                            - {{(bfm_pkg::CNT_W-1){1'b0}}, rd_ok};
    // Level comparisons on the fill that will hold after this edge.
    assign raw_d.not_empty      = (cnt_d != bfm_pkg::CNT_ZERO);
    assign raw_d.almost_empty_n = (cnt_d > x_q);
    assign raw_d.almost_full_n  = (cnt_d < (bfm_pkg::CNT_FULL - x_q));
    assign raw_d.not_full       = (cnt_d != bfm_pkg::CNT_FULL);

    always_ff @(posedge aclk) begin
      if (wr_ok) begin
        mem[wr_ptr_q] <= q_wdata[q];
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        cnt_q[q] <= bfm_pkg::CNT_ZERO;
        q_out_q[q] <= '0;
      end else begin
        wr_ptr_q <= wr_ptr_q + {{(bfm_pkg::PTR_W-1){1'b0}}, wr_ok};
        rd_ptr_q <= rd_ptr_q + {{(bfm_pkg::PTR_W-1){1'b0}}, rd_ok};
        cnt_q[q] <= cnt_d;
        if (rd_ok) begin
          q_out_q[q] <= q_pg[q] ? parity_fill(mem[rd_ptr_q], odd_q) : mem[rd_ptr_q];
        end
      end
    end

    // A flag drops on the same edge as the level, but rises only on the second edge.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stage_q  <= bfm_pkg::FLAGS_RST;
        stage2_q <= bfm_pkg::FLAGS_RST;
        flag_q[q] <= bfm_pkg::FLAGS_RST;
      end else begin
        stage_q  <= raw_d;
        stage2_q <= stage_q;
        flag_q[q] <= raw_d & stage_q & stage2_q;
      end
    end
  end

  assign porta_not_full       = flag_q[bfm_pkg::Q_A_TO_B].not_full;
  assign porta_almost_full_n  = flag_q[bfm_pkg::Q_A_TO_B].almost_full_n;
  assign portb_not_empty      = flag_q[bfm_pkg::Q_A_TO_B].not_empty;
  assign portb_almost_empty_n = flag_q[bfm_pkg::Q_A_TO_B].almost_empty_n;
  assign portb_not_full       = flag_q[bfm_pkg::Q_B_TO_A].not_full;
  assign portb_almost_full_n  = flag_q[bfm_pkg::Q_B_TO_A].almost_full_n;
  assign porta_not_empty      = flag_q[bfm_pkg::Q_B_TO_A].not_empty;
  assign porta_almost_empty_n = flag_q[bfm_pkg::Q_B_TO_A].almost_empty_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Mailboxes: a write is taken only while the box is empty, a read empties it.

  logic [bfm_pkg::DATA_W-1:0] mail_ab_q;
  logic [bfm_pkg::DATA_W-1:0] mail_ba_q;
  logic                       mail_ab_n_q;
  logic                       mail_ba_n_q;
  wire logic mail_ab_wr = op_a.mail_wr & mail_ab_n_q;
  wire logic mail_ba_wr = op_b.mail_wr & mail_ba_n_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mail_ab_q   <= '0;
      mail_ba_q   <= '0;
      mail_ab_n_q <= 1'b1;
      mail_ba_n_q <= 1'b1;
    end else begin
      if (mail_ab_wr) begin
        mail_ab_q <= porta_data_in;
      end
      if (mail_ba_wr) begin
        mail_ba_q <= portb_data_in;
      end
      // A new write wins over a read in the same cycle.
      mail_ab_n_q <= mail_ab_wr ? 1'b0 : (mail_ab_n_q | op_b.mail_rd);
      mail_ba_n_q <= mail_ba_wr ? 1'b0 : (mail_ba_n_q | op_a.mail_rd);
    end
  end

  assign a_to_b_mail_flag_n = mail_ab_n_q;
  assign b_to_a_mail_flag_n = mail_ba_n_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Output buses and parity error flags.

  wire logic mail_gen_a = op_a.mail_rd & porta_parity_generate;
  wire logic mail_gen_b = op_b.mail_rd & portb_parity_generate;

  assign porta_data_oe  = ~porta_chip_select_n & ~porta_write_not_read;
  assign portb_data_oe  = ~portb_chip_select_n & ~portb_write_not_read;
  assign porta_data_out = ~porta_mailbox_select ? q_out_q[bfm_pkg::Q_B_TO_A] :
                          porta_parity_generate ? parity_fill(mail_ba_q, odd_q) :
                          mail_ba_q;
  assign portb_data_out = ~portb_mailbox_select ? q_out_q[bfm_pkg::Q_A_TO_B] :
                          portb_parity_generate ? parity_fill(mail_ab_q, odd_q) :
                          mail_ab_q;
  assign porta_parity_error_n = mail_gen_a | ~parity_fail(porta_data_in, odd_q);
  assign portb_parity_error_n = mail_gen_b | ~parity_fail(portb_data_in, odd_q);

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic                       aw_held_q;
  logic                       w_held_q;
  logic [bfm_pkg::AXI_AW-1:0] awaddr_q;
  logic [31:0]                wdata_q;
  logic [3:0]                 wstrb_q;
  logic                       bvalid_q;
  logic [1:0]                 bresp_q;
  logic                       rvalid_q;
  logic [1:0]                 rresp_q;
  logic [31:0]                rdata_q;
  logic [31:0]                rd_word;
  logic                       rd_hit;

  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take  = s_axi_wvalid & s_axi_wready;
  wire logic ar_take = s_axi_arvalid & s_axi_arready;
  wire logic aw_have = aw_held_q | aw_take;
  wire logic w_have  = w_held_q | w_take;
  wire logic wr_fire = aw_have & w_have;
  wire logic [bfm_pkg::AXI_AW-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire logic [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire logic [3:0]  wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire logic wr_ctrl = wr_fire & (wr_addr == bfm_pkg::OFS_CTRL);
  wire logic wr_hit  = (wr_addr == bfm_pkg::OFS_CTRL) | (wr_addr == bfm_pkg::OFS_STATUS) |
                       (wr_addr == bfm_pkg::OFS_LEVEL);

  wire logic [31:0] status_word = {20'h00000, ~portb_parity_error_n, ~porta_parity_error_n,
                                   mail_ba_n_q, mail_ab_n_q,
                                   flag_q[bfm_pkg::Q_B_TO_A], flag_q[bfm_pkg::Q_A_TO_B]};
  wire logic [31:0] level_word  = {9'h000, cnt_q[bfm_pkg::Q_B_TO_A],
                                   9'h000, cnt_q[bfm_pkg::Q_A_TO_B]};

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    case (s_axi_araddr)
      bfm_pkg::OFS_CTRL:   rd_word[bfm_pkg::CTRL_ODD_BIT] = odd_q;
      bfm_pkg::OFS_STATUS: rd_word = status_word;
      bfm_pkg::OFS_LEVEL:  rd_word = level_word;
      default:             rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= bfm_pkg::RESP_OKAY;
      odd_q     <= bfm_pkg::CTRL_ODD_RST;
    end else begin
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_held_q <= aw_have & ~wr_fire;
      w_held_q  <= w_have & ~wr_fire;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? bfm_pkg::RESP_OKAY : bfm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (wr_ctrl & wr_strb[0]) begin
        odd_q <= wr_data[bfm_pkg::CTRL_ODD_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= bfm_pkg::RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? bfm_pkg::RESP_OKAY : bfm_pkg::RESP_SLVERR;
      rdata_q  <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// ---- dv/bfm_chk.sv ----
// Concurrent checks on the flags of the queue written by port B, the A to B mailbox flag and the parity flags.
`timescale 1ns/1ps
module bfm_chk (
  // Clock, reset and offset strap.
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [1:0] offset_select,
  // Port A pins.
  input wire logic       porta_chip_select_n,
  input wire logic       porta_write_not_read,
  input wire logic       porta_enable,
  input wire logic       porta_mailbox_select,
  input wire logic       porta_parity_generate,
  input wire logic       porta_not_empty,
  input wire logic       porta_almost_empty_n,
  input wire logic       porta_parity_error_n,
  // Port B pins.
  input wire logic       portb_chip_select_n,
  input wire logic       portb_write_not_read,
  input wire logic       portb_enable,
  input wire logic       portb_mailbox_select,
  input wire logic       portb_parity_generate,
  input wire logic       portb_almost_full_n,
  input wire logic       portb_not_full,
  input wire logic       portb_parity_error_n,
  input wire logic       a_to_b_mail_flag_n
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] x_q;
  logic [6:0] x_d;
  wire sel_a = !porta_chip_select_n && porta_enable;
  wire sel_b = !portb_chip_select_n && portb_enable;
  wire amw = sel_a && porta_write_not_read && porta_mailbox_select;
  wire amr = sel_a && !porta_write_not_read && porta_mailbox_select;
  wire bmr = sel_b && !portb_write_not_read && portb_mailbox_select;
  wire qwr_b = sel_b && portb_write_not_read && !portb_mailbox_select && portb_not_full;
  wire qrd_a = sel_a && !porta_write_not_read && !porta_mailbox_select && porta_not_empty;
  wire [6:0] af_lvl = bfm_pkg::CNT_FULL - x_q;
  assign x_d = (offset_select == 2'h0) ? bfm_pkg::X_PRESET0 :
               (offset_select == 2'h1) ? bfm_pkg::X_PRESET1 :
               (offset_select == 2'h2) ? bfm_pkg::X_PRESET2 : bfm_pkg::X_PRESET3;
  assign cnt_d = cnt_q + {6'h00, qwr_b} - {6'h00, qrd_a};
  // Fill level of the queue written by port B.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 7'h00;
      x_q   <= x_d;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_af_cross;
    $past(cnt_q) == af_lvl && cnt_q + 7'h01 == af_lvl && !portb_almost_full_n;
  endsequence
  a_mail_set: assert property (amw && a_to_b_mail_flag_n |=> !a_to_b_mail_flag_n)
    else $error("mailbox flag not lowered by write");
  a_mail_keep: assert property (!a_to_b_mail_flag_n && !bmr |=> !a_to_b_mail_flag_n)
    else $error("mailbox flag released without read");
  a_mail_clear: assert property (bmr && !a_to_b_mail_flag_n |=> a_to_b_mail_flag_n)
    else $error("mailbox flag not raised by read");
  a_pgen_err_a: assert property (amr && porta_parity_generate |-> porta_parity_error_n)
    else $error("port A parity error during generated mailbox read");
  a_pgen_err_b: assert property (bmr && portb_parity_generate |-> portb_parity_error_n)
    else $error("port B parity error during generated mailbox read");
  a_empty_release: assert property (qwr_b && cnt_q == 7'h00 |-> ##2 !porta_not_empty
    ##1 porta_not_empty) else $error("not empty flag release timing");
  a_low_level: assert property (cnt_q <= x_q |-> !porta_almost_empty_n &&
    (cnt_q != 7'h00 || !porta_not_empty)) else $error("reader flags wrong at low fill");
  a_high_level: assert property (cnt_q >= af_lvl |-> !portb_almost_full_n)
    else $error("almost full flag high at high fill");
  a_full_level: assert property (cnt_q == bfm_pkg::CNT_FULL |-> !portb_not_full)
    else $error("not full flag high at full");
  a_af_sync: assert property (s_af_cross ##0 !qwr_b ##1 !qwr_b
    |-> !portb_almost_full_n ##1 portb_almost_full_n) else $error("almost full release timing");
endmodule
bind bfm_top bfm_chk bfm_chk_i (.*);

// ---- dv/bfm_port_host.sv ----
// Host model driving one queue port of the block.
`timescale 1ns/1ps
module bfm_port_host (
  // Clock.
  input  wire logic        clk,
  // Control pins toward the block.
  output logic             cs_n,
  output logic             wnr,
  output logic             en,
  output logic             mb,
  output logic             pg,
  // Data bus.
  output logic      [35:0] din,
  input  wire logic [35:0] dout,
  input  wire logic        oe
);
  logic [35:0] drv = 36'h0;
  // Wire level: the block, else the host while writing, else an inverted pattern.
  assign din = oe ? dout : (!cs_n && wnr) ? drv : ~drv;
  initial {cs_n, wnr, en, mb, pg} = 5'h10;
  // One transfer, requested after an edge and taken at the next edge.
  task automatic op(input logic w, input logic m, input logic g, input logic [35:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    wnr  <= w;
    en   <= 1'b1;
    mb   <= m;
    pg   <= g;
    drv  <= d;
    @(posedge clk);
    en <= 1'b0;
  endtask
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the queue pair, mailboxes, parity and register slave.
`timescale 1ns/1ps
module tb;
  localparam int XV = int'(bfm_pkg::X_PRESET3);
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [1:0] offset_select = 2'h3;
  wire porta_chip_select_n, porta_write_not_read, porta_enable, porta_mailbox_select;
  wire porta_parity_generate, porta_data_oe, portb_chip_select_n, portb_write_not_read;
  wire portb_enable, portb_mailbox_select, portb_parity_generate, portb_data_oe;
  wire [35:0] porta_data_in, porta_data_out, portb_data_in, portb_data_out;
  wire porta_not_empty, porta_almost_empty_n, porta_almost_full_n, porta_not_full;
  wire portb_not_empty, portb_almost_empty_n, portb_almost_full_n, portb_not_full;
  wire porta_parity_error_n, portb_parity_error_n, a_to_b_mail_flag_n, b_to_a_mail_flag_n;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int err_total = 0;
  int total_checks = 0;
  logic [35:0] q[$];
  always #12.5 aclk = ~aclk;
  bfm_top bfm_top_i (.*);
  bfm_port_host host_a (.clk(aclk), .cs_n(porta_chip_select_n), .wnr(porta_write_not_read),
    .en(porta_enable), .mb(porta_mailbox_select), .pg(porta_parity_generate),
    .din(porta_data_in), .dout(porta_data_out), .oe(porta_data_oe));
  bfm_port_host host_b (.clk(aclk), .cs_n(portb_chip_select_n), .wnr(portb_write_not_read),
    .en(portb_enable), .mb(portb_mailbox_select), .pg(portb_parity_generate),
    .din(portb_data_in), .dout(portb_data_out), .oe(portb_data_oe));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [35:0] gen(input logic [35:0] d, input logic o);
    gen = d;
    for (int i = 0; i < 4; i++) gen[9*i+8] = o ^ (^d[9*i +: 8]);
  endfunction
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkf(input int n);
    bfm_pkg::bfm_flags_type e, g;
    e = '{n > 0, n > XV, n < 64 - XV, n < 64};
    g = '{porta_not_empty, porta_almost_empty_n, portb_almost_full_n, portb_not_full};
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] flags at fill %0d expected %h seen %h", n, e, g);
    end
  endtask
  // One register access with a bounded wait.
  task automatic ax(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e,
                    input logic [1:0] er);
    logic ta, tw, tr, done;
    logic [31:0] rd;
    logic [1:0] rs;
    int n;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (!done && n < 40) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_arvalid & s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      rd = s_axi_rdata;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk("axi answer", 36'h1, 36'(done));
    chk("axi resp", 36'(er), 36'(rs));
    if (!wr) chk("axi data", 36'(e), 36'(rd));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    ax(1'b0, bfm_pkg::OFS_CTRL, 32'h0, 32'h1, bfm_pkg::RESP_OKAY);
    ax(1'b0, bfm_pkg::OFS_STATUS, 32'h0, 32'h333, bfm_pkg::RESP_OKAY);
    ax(1'b0, 4'hC, 32'h0, 32'h0, bfm_pkg::RESP_SLVERR);
    ax(1'b1, 4'hC, 32'h5, 32'h0, bfm_pkg::RESP_SLVERR);
    $display("register test done");
  endtask
  task automatic t_mail();
    logic [35:0] w;
    w = 36'h1_2345_6789;
    host_a.op(1'b1, 1'b1, 1'b0, w);
    #1 chk("a to b flag", 36'h0, 36'(a_to_b_mail_flag_n));
    host_a.op(1'b1, 1'b1, 1'b0, ~w);
    host_b.op(1'b0, 1'b1, 1'b0, 36'h0);
    #1 chk("a to b mail", w, portb_data_out);
    chk("a to b flag", 36'h1, 36'(a_to_b_mail_flag_n));
    host_b.op(1'b0, 1'b1, 1'b1, 36'h0);
    #1 chk("a to b gen", gen(w, 1'b1), portb_data_out);
    host_b.op(1'b1, 1'b1, 1'b0, ~w);
    #1 chk("b to a flag", 36'h0, 36'(b_to_a_mail_flag_n));
    host_a.op(1'b0, 1'b1, 1'b1, 36'h0);
    #1 chk("b to a gen", gen(~w, 1'b1), porta_data_out);
    host_a.op(1'b0, 1'b1, 1'b0, 36'h0);
    #1 chk("b to a mail", ~w, porta_data_out);
    chk("b to a flag", 36'h1, 36'(b_to_a_mail_flag_n));
    $display("mailbox test done");
  endtask
  task automatic t_flags();
    for (int k = 1; k <= 65; k++) begin
      host_b.op(1'b1, 1'b0, 1'b0, 36'(k));
      repeat (2) @(posedge aclk);
      #1 chkf(k > 64 ? 64 : k);
    end
    for (int r = 1; r <= 65; r++) begin
      host_a.op(1'b0, 1'b0, 1'b0, 36'h0);
      #1 chk("queue word", 36'(r > 64 ? 64 : r), porta_data_out);
      repeat (2) @(posedge aclk);
      #1 chkf(r > 64 ? 0 : 64 - r);
    end
    $display("flag test done");
  endtask
  task automatic t_parity();
    logic [35:0] g;
    for (int o = 1; o >= 0; o--) begin
      if (o == 0) begin
        ax(1'b1, bfm_pkg::OFS_CTRL, 32'h0, 32'h0, bfm_pkg::RESP_OKAY);
        ax(1'b0, bfm_pkg::OFS_CTRL, 32'h0, 32'h0, bfm_pkg::RESP_OKAY);
      end
      for (int i = 0; i < 5; i++) begin
        g = gen(36'h0_5A3C_9612 + 36'(i), o[0]);
        if (i < 4) g[9*i+8] = ~g[9*i+8];
        host_a.op(1'b1, 1'b0, 1'b0, g);
        #1 chk("parity flag", 36'(i == 4), 36'(porta_parity_error_n));
        q.push_back(g);
      end
    end
    repeat (2) @(posedge aclk);
    #1 chk("ab flags", 36'hF, 36'({portb_not_empty, portb_almost_empty_n,
      porta_almost_full_n, porta_not_full}));
    for (int k = 0; k <= 10; k++) begin
      host_b.op(1'b0, 1'b0, k >= 9, 36'h0);
      #1 chk("stored word", k < 9 ? q[k] : gen(q[9], 1'b0), portb_data_out);
    end
    $display("parity test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_mail();
    t_flags();
    t_parity();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    final_report();
  end
endmodule
